// File: design/aesc_block_encrypt.sv
// top of the single-block 128-bit encrypt controller: registers, sequencer, core handshake
// assumes a shared cipher core outside, a data ram behind a simple req/ack dma port
//
// Functional notes
// - a write to start at 0x000 begins one block encryption when the core is idle
// - start while the shared core is occupied raises error and begins nothing
// - a write to stop at 0x004 aborts a running encryption, except in the single ST_STORE cycle, where it is ignored
// - an encryption aborted by stop raises the error event
// - done flag at 0x100 is set once the ciphertext is written back
// - error flag at 0x104 is set whenever an encryption is aborted
// - enable-set bit 0 write one enables done interrupt; reads show the enable
// - enable-set bit 1 write one enables error interrupt; reads show the enable
// - 32-bit pointer at 0x504, reset zero, addresses every dma access
// - a block still running 7.2 microseconds (288 cycles) after its start is aborted with the error event
// - ram structure: key at 0, cleartext at 16, ciphertext at 32
// - lowest priority on the core; a conflict aborts with the error event
// - no dma access is outstanding when done or an abort error is raised; a start refused mid-run raises error at once
// - encryption only, 128-bit key, no decryption path
`include "aesc_map.svh"

module aesc_block_encrypt (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire aesc_pkg::aesc_reg_req_type regReq,
  output logic [31:0] regRdData,
  // trigger fabric tasks and events
  input wire logic startTrig,
  input wire logic stopTrig,
  output logic doneEvt,
  output logic errEvt,
  // interrupt
  output logic irq,
  // dma master towards data ram
  output aesc_pkg::aesc_dma_req_type dmaOut,
  input wire logic dmaAck,
  input wire logic [31:0] dmaRdData,
  // shared cipher core
  input wire logic coreBusy,
  input wire logic coreConflict,
  output logic coreReq,
  output logic [127:0] coreKey,
  output logic [127:0] coreText,
  input wire logic coreDone,
  input wire logic [127:0] coreResult
);
  import aesc_pkg::*;

  localparam logic [8:0] RunMaxCyc = 9'(`AESC_RUN_MAX_CYC);

  aesc_state_type state_q;
  logic [31:0] ptr_q;
  logic [127:0] result_q;
  logic [8:0] runCnt_q;
  logic abortPend_q;
  logic errPend_q;
  logic [1:0] evtSet;
  logic startHit;
  logic stopHit;
  logic wrHit;
  logic rdHit;
  logic moverGo;
  logic moverWrite;
  logic [31:0] moverBase;
  logic moverDone;
  logic [127:0] moverBlock;
  logic [1:0] flags;
  logic [1:0] enables;
  logic runLimit;

  ////////////////////////////////////////////////////////////////////////
  // register decode: task writes are one-shot, bit 0 must be one to fire
  assign wrHit = regReq.wrEn;
  assign rdHit = regReq.rdEn;
  assign startHit = startTrig ||
    (wrHit && regReq.addr == `AESC_OFS_START && regReq.wdata[`AESC_BIT_TASK]);
  assign stopHit = stopTrig ||
    (wrHit && regReq.addr == `AESC_OFS_STOP && regReq.wdata[`AESC_BIT_TASK]);

  // pointer register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ptr_q <= `AESC_PTR_RESET;
    end else if (wrHit && regReq.addr == `AESC_OFS_PTR) begin
      ptr_q <= regReq.wdata;
    end
  end

  // read data, one cycle after the strobe; unmapped and task offsets read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdData <= 32'h00000000;
    end else if (rdHit) begin
      case (regReq.addr)
        `AESC_OFS_DONE: regRdData <= {31'h00000000, flags[0]};
        `AESC_OFS_ERROR: regRdData <= {31'h00000000, flags[1]};
        `AESC_OFS_IRQ_SET: regRdData <= {30'h00000000, enables};
        `AESC_OFS_IRQ_CLR: regRdData <= {30'h00000000, enables};
        `AESC_OFS_PTR: regRdData <= ptr_q;
        default: regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // run-time watchdog: a block that cannot finish in time is aborted
  // rather than left hanging, so software always sees one of the two events
  assign runLimit = (runCnt_q >= RunMaxCyc);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      runCnt_q <= 9'h000;
    end else if (state_q == ST_IDLE) begin
      runCnt_q <= 9'h000;
    end else if (!runLimit) begin
      runCnt_q <= runCnt_q + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: key read, cleartext read, cipher, ciphertext write
  // the only direction offered to the core is encrypt with a 128-bit key
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      abortPend_q <= 1'b0;
      errPend_q <= 1'b0;
      coreReq <= 1'b0;
      coreKey <= '0;
      coreText <= '0;
      result_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          abortPend_q <= 1'b0;
          errPend_q <= 1'b0;
          if (startHit && !coreBusy) begin
            state_q <= ST_KEY;
          end
        end
        ST_KEY: begin
          if (stopHit || runLimit) begin
            abortPend_q <= 1'b1;
          end
          if (moverDone) begin
            coreKey <= moverBlock;
            state_q <= (abortPend_q || stopHit || runLimit) ? ST_IDLE : ST_TEXT;
          end
        end
        ST_TEXT: begin
          if (stopHit || runLimit) begin
            abortPend_q <= 1'b1;
          end
          if (moverDone) begin
            coreText <= moverBlock;
            if (abortPend_q || stopHit || runLimit) begin
              state_q <= ST_IDLE;
            end else begin
              coreReq <= 1'b1;
              state_q <= ST_CIPHER;
            end
          end
        end
        ST_CIPHER: begin
          if (stopHit || coreConflict || runLimit) begin
            coreReq <= 1'b0;
            state_q <= ST_IDLE;
          end else if (coreDone) begin
            coreReq <= 1'b0;
            result_q <= coreResult;
            state_q <= ST_STORE;
          end
        end
        ST_STORE: begin
          state_q <= ST_DRAIN;
        end
        ST_DRAIN: begin
          if (stopHit || runLimit) begin
            abortPend_q <= 1'b1;
          end
          if (moverDone) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mover launches: key and text reads, then the ciphertext write
  always_comb begin
    moverGo = 1'b0;
    moverWrite = 1'b0;
    moverBase = ptr_q + `AESC_KEY_OFS;
    case (state_q)
      ST_IDLE: moverGo = startHit && !coreBusy;
      ST_KEY: begin
        moverGo = moverDone && !(abortPend_q || stopHit || runLimit);
        moverBase = ptr_q + `AESC_TEXT_OFS;
      end
      ST_STORE: begin
        moverGo = 1'b1;
        moverWrite = 1'b1;
        moverBase = ptr_q + `AESC_CIPHER_OFS;
      end
      default: moverGo = 1'b0;
    endcase
  end

  aesc_word_mover u_mover (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .go(moverGo),
    .goWrite(moverWrite),
    .goBase(moverBase),
    .goData(result_q),
    .abort(abortPend_q || stopHit || runLimit),
    .busy(),
    .done(moverDone),
    .rdBlock(moverBlock),
    .dmaOut(dmaOut),
    .dmaAck(dmaAck),
    .dmaRdData(dmaRdData)
  );

  ////////////////////////////////////////////////////////////////////////
  // event generation; done and abort errors only fire once the mover is idle, a start while running errors at once
  always_comb begin
    evtSet = 2'h0;
    case (state_q)
      ST_IDLE: evtSet[1] = startHit && coreBusy;
      ST_KEY, ST_TEXT: evtSet[1] = moverDone && (abortPend_q || stopHit || runLimit);
      ST_CIPHER: evtSet[1] = stopHit || coreConflict || runLimit;
      ST_DRAIN: begin
        evtSet[0] = moverDone && !(abortPend_q || stopHit || runLimit);
        evtSet[1] = moverDone && (abortPend_q || stopHit || runLimit);
      end
      default: evtSet = 2'h0;
    endcase
    if (state_q != ST_IDLE && startHit) begin
      evtSet[1] = 1'b1;
    end
  end

  // event pulses to the trigger fabric
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      doneEvt <= 1'b0;
      errEvt <= 1'b0;
    end else begin
      doneEvt <= evtSet[0];
      errEvt <= evtSet[1];
    end
  end

  aesc_irq_unit u_irq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .evtSet(evtSet),
    .flagWr({wrHit && regReq.addr == `AESC_OFS_ERROR, wrHit && regReq.addr == `AESC_OFS_DONE}),
    .flagRd({rdHit && regReq.addr == `AESC_OFS_ERROR, rdHit && regReq.addr == `AESC_OFS_DONE}),
    .flagWrBit(regReq.wdata[`AESC_BIT_EVENT]),
    .enSetWr(wrHit && regReq.addr == `AESC_OFS_IRQ_SET),
    .enClrWr(wrHit && regReq.addr == `AESC_OFS_IRQ_CLR),
    .enBits({regReq.wdata[`AESC_BIT_IRQ_ERR], regReq.wdata[`AESC_BIT_IRQ_DONE]}),
    .flags(flags),
    .enables(enables),
    .irq(irq)
  );

endmodule : aesc_block_encrypt

// File: include/aesc_map.svh
// register offsets, field positions, reset values and timing counts of the block-encrypt controller
// assumes a 12-bit word-aligned register address and a 40 MHz system clock
`ifndef AESC_MAP_SVH
`define AESC_MAP_SVH

// register offsets (byte addresses)
`define AESC_OFS_START 12'h000
`define AESC_OFS_STOP 12'h004
`define AESC_OFS_DONE 12'h100
`define AESC_OFS_ERROR 12'h104
`define AESC_OFS_IRQ_SET 12'h304
`define AESC_OFS_IRQ_CLR 12'h308
`define AESC_OFS_PTR 12'h504

// field positions
`define AESC_BIT_TASK 0
`define AESC_BIT_EVENT 0
`define AESC_BIT_IRQ_DONE 0
`define AESC_BIT_IRQ_ERR 1

// reset values
`define AESC_PTR_RESET 32'h00000000
`define AESC_IRQ_EN_RESET 2'h0

// layout of the block structure in ram
`define AESC_KEY_OFS 32'h00000000
`define AESC_TEXT_OFS 32'h00000010
`define AESC_CIPHER_OFS 32'h00000020
`define AESC_BLOCK_WORDS 3'h4
`define AESC_WORD_BYTES 32'h00000004

// timing: longest run time of one block, in ns, and its cycle count (rounded down)
`define AESC_CLK_MHZ 40
`define AESC_RUN_MAX_NS 7200
`define AESC_RUN_MAX_CYC ((`AESC_RUN_MAX_NS * `AESC_CLK_MHZ) / 1000)

`endif

// File: include/aesc_pkg.sv
// types shared by the block-encrypt controller and its helpers
// assumes aesc_map.svh for all numeric constants
package aesc_pkg;

  // register port request from software
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [11:0] addr;
    logic [31:0] wdata;
  } aesc_reg_req_type;

  // dma master request towards data ram
  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } aesc_dma_req_type;

  // sequencer states of one block operation
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_KEY,
    ST_TEXT,
    ST_CIPHER,
    ST_STORE,
    ST_DRAIN
  } aesc_state_type;

endpackage : aesc_pkg

// File: design/aesc_word_mover.sv
// dma word mover: reads or writes four consecutive 32-bit words of data ram
// assumes a ram that holds req until it answers with a one-cycle ack
`include "aesc_map.svh"

module aesc_word_mover (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control from the sequencer
  input wire logic go,
  input wire logic goWrite,
  input wire logic [31:0] goBase,
  input wire logic [127:0] goData,
  input wire logic abort,
  output logic busy,
  output logic done,
  output logic [127:0] rdBlock,
  // dma master
  output aesc_pkg::aesc_dma_req_type dmaOut,
  input wire logic dmaAck,
  input wire logic [31:0] dmaRdData
);
  import aesc_pkg::*;

  logic [2:0] beat_q;
  logic [127:0] shift_q;
  logic lastBeat;

  assign lastBeat = (beat_q == `AESC_BLOCK_WORDS - 3'h1);
  assign busy = dmaOut.req;

  ////////////////////////////////////////////////////////////////////////
  // beat sequencing: one word per ack, first word at the lowest address
  // an abort only takes effect at an ack, so no access is left half done
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dmaOut <= '0;
      beat_q <= 3'h0;
      shift_q <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go && !dmaOut.req) begin
        dmaOut.req <= 1'b1;
        dmaOut.write <= goWrite;
        dmaOut.addr <= goBase;
        dmaOut.wdata <= goData[127:96];
        shift_q <= {goData[95:0], 32'h00000000};
        beat_q <= 3'h0;
      end else if (dmaOut.req && dmaAck) begin
        if (!dmaOut.write) begin
          shift_q <= {shift_q[95:0], dmaRdData}; // read words enter from the bottom
        end else begin
          shift_q <= {shift_q[95:0], 32'h00000000};
          dmaOut.wdata <= shift_q[127:96];
        end
        if (lastBeat || abort) begin
          dmaOut.req <= 1'b0;
          done <= 1'b1;
        end else begin
          dmaOut.addr <= dmaOut.addr + `AESC_WORD_BYTES;
          beat_q <= beat_q + 3'h1;
        end
      end
    end
  end

  // assembled read block, valid in the cycle done is high
  assign rdBlock = shift_q;

endmodule : aesc_word_mover

// File: design/aesc_irq_unit.sv
// event flags, interrupt enables and the level interrupt of the block-encrypt controller
// assumes one-cycle set pulses and one-cycle register strobes from the main module
`include "aesc_map.svh"

module aesc_irq_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // hardware events, bit 0 done, bit 1 error
  input wire logic [1:0] evtSet,
  // software access
  input wire logic [1:0] flagWr,
  input wire logic [1:0] flagRd,
  input wire logic flagWrBit,
  input wire logic enSetWr,
  input wire logic enClrWr,
  input wire logic [1:0] enBits,
  // state
  output logic [1:0] flags,
  output logic [1:0] enables,
  output logic irq
);
  import aesc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // per-event sticky flag: a hardware set beats a clear in the same cycle
  for (genvar i = 0; i < 2; i++) begin : g_evt
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        flags[i] <= 1'b0;
      end else if (evtSet[i]) begin
        flags[i] <= 1'b1;
      end else if (flagRd[i] || (flagWr[i] && !flagWrBit)) begin
        flags[i] <= 1'b0;
      end
    end
  end

  // enables: write-one-to-set and write-one-to-clear views of one register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      enables <= `AESC_IRQ_EN_RESET;
    end else if (enSetWr) begin
      enables <= enables | enBits;
    end else if (enClrWr) begin
      enables <= enables & ~enBits;
    end
  end

  // registered level output, one cycle behind the flags
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & enables);
    end
  end

endmodule : aesc_irq_unit

// File: verif/aesc_ram_model.sv
// data ram behind the dma port, 64 words seen through the low address bits
// assumes req is held until ack; slow adds two wait cycles to every beat
module aesc_ram_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // dma slave side
  input wire aesc_pkg::aesc_dma_req_type dmaOut,
  input wire logic slow,
  output logic dmaAck = 1'b0,
  output logic [31:0] dmaRdData = 32'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  import aesc_pkg::*;
  logic [31:0] mem [0:63];
  logic [1:0] waitQ;
  ////////////////////////////////////////////////////////////
  // one beat per ack; read data is scrambled outside the ack cycle so stale data never matches
  always @(posedge mclk) begin
    dmaAck <= 1'b0;
    dmaRdData <= ~dmaRdData;
    if (sys_rst) begin
      waitQ <= 2'h0;
    end else if (dmaOut.req && !dmaAck) begin
      if (waitQ < {slow, 1'b0}) begin
        waitQ <= waitQ + 2'h1;
      end else begin
        waitQ <= 2'h0;
        dmaAck <= 1'b1;
        if (dmaOut.write) mem[dmaOut.addr[7:2]] <= dmaOut.wdata;
        else dmaRdData <= mem[dmaOut.addr[7:2]];
      end
    end
  end
endmodule : aesc_ram_model

// File: verif/aesc_block_encrypt_properties.sv
// port checker of the block-encrypt controller
// assumes one clock domain and the register map header
`include "aesc_map.svh"
module aesc_props (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port and triggers
  input wire aesc_pkg::aesc_reg_req_type regReq,
  input wire logic [31:0] regRdData,
  input wire logic startTrig,
  input wire logic stopTrig,
  // events and interrupt
  input wire logic doneEvt,
  input wire logic errEvt,
  input wire logic irq,
  // dma and core
  input wire aesc_pkg::aesc_dma_req_type dmaOut,
  input wire logic dmaAck,
  input wire logic coreBusy,
  input wire logic coreConflict,
  input wire logic coreReq
);
  timeunit 1ns;
  timeprecision 100ps;
  import aesc_pkg::*;
  // watchdog count plus the event register stage and one spare cycle
  localparam int RUN_MAX = `AESC_RUN_MAX_CYC + 2;
  logic startAny, stopAny, runQ;
  logic [1:0] enQ;
  logic [31:0] ptrQ, offs;
  logic [9:0] cntQ;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // task strobes from software or fabric
  assign startAny = startTrig | (regReq.wrEn & regReq.addr == `AESC_OFS_START & regReq.wdata[0]);
  assign stopAny = stopTrig | (regReq.wrEn & regReq.addr == `AESC_OFS_STOP & regReq.wdata[0]);
  assign offs = dmaOut.addr - ptrQ;
  // shadow of pointer and enables
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ptrQ <= 32'h0;
      enQ <= 2'h0;
    end else if (regReq.wrEn) begin
      if (regReq.addr == `AESC_OFS_PTR) ptrQ <= regReq.wdata;
      if (regReq.addr == `AESC_OFS_IRQ_SET) enQ <= enQ | regReq.wdata[1:0];
      if (regReq.addr == `AESC_OFS_IRQ_CLR) enQ <= enQ & ~regReq.wdata[1:0];
    end
  end
  // run tracker; an error right after a start belongs to that refused start
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      runQ <= 1'b0;
      cntQ <= 10'h0;
    end else if (startAny && !coreBusy && !runQ) begin
      runQ <= 1'b1;
      cntQ <= 10'h0;
    end else if (doneEvt || (errEvt && !$past(startAny))) begin
      runQ <= 1'b0;
    end else if (runQ) begin
      cntQ <= cntQ + 10'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  a_rd_idle: assert property (!$past(regReq.rdEn) |-> regRdData == 32'h0)
    else $error("read data outside the read cycle");
  a_busy_err: assert property (startAny && coreBusy |=> errEvt)
    else $error("no error for start on busy core");
  a_busy_nodma: assert property (startAny && coreBusy && !runQ |=> !dmaOut.req ##1 !dmaOut.req)
    else $error("dma began on busy core");
  a_first_read: assert property (startAny && !coreBusy && !runQ |=> dmaOut.req && !dmaOut.write && dmaOut.addr == ptrQ)
    else $error("start did not fetch at pointer");
  a_dma_hold: assert property (dmaOut.req && !dmaAck |=> dmaOut.req && $stable(dmaOut.addr) && $stable(dmaOut.write))
    else $error("dma request changed before ack");
  a_dma_span: assert property (dmaOut.req |-> (dmaOut.write ? (offs >= 32'h20 && offs <= 32'h2c) : offs <= 32'h1c))
    else $error("dma address outside structure");
  a_done_quiet: assert property (doneEvt |-> !dmaOut.req)
    else $error("dma pending at done");
  a_stop_abort: assert property (coreReq && stopAny |=> !coreReq ##[0:4] errEvt)
    else $error("stop did not abort");
  a_conflict_abort: assert property (coreReq && coreConflict |=> !coreReq ##[0:4] errEvt)
    else $error("conflict did not abort");
  a_irq_raise: assert property ((doneEvt && enQ[0]) || (errEvt && enQ[1]) |=> irq)
    else $error("enabled event gave no interrupt");
  a_irq_masked: assert property (enQ == 2'h0 && $past(enQ) == 2'h0 |-> !irq)
    else $error("interrupt while disabled");
  a_run_bound: assert property (runQ |-> cntQ <= RUN_MAX)
    else $error("run too long");
endmodule : aesc_props
bind aesc_block_encrypt aesc_props u_props (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .regReq(regReq),
  .regRdData(regRdData),
  .startTrig(startTrig),
  .stopTrig(stopTrig),
  .doneEvt(doneEvt),
  .errEvt(errEvt),
  .irq(irq),
  .dmaOut(dmaOut),
  .dmaAck(dmaAck),
  .coreBusy(coreBusy),
  .coreConflict(coreConflict),
  .coreReq(coreReq)
);

// File: verif/testbench.sv
// self-checking bench of the block-encrypt controller
// assumes the ram model and a behavioural cipher core that answers after nine cycles
`include "aesc_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import aesc_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, startTrig = 1'b0, stopTrig = 1'b0, slow = 1'b0;
  logic coreBusy = 1'b0, coreConflict = 1'b0, coreDone = 1'b0, coreHold = 1'b0;
  logic doneEvt, errEvt, irq, dmaAck, coreReq;
  logic [31:0] regRdData, dmaRdData, v;
  logic [127:0] coreKey, coreText, coreResult = 128'h0;
  logic [3:0] coreCnt = 4'h0;
  aesc_reg_req_type regReq = '0;
  aesc_dma_req_type dmaOut;
  int badCount = 0, nTests = 0, n, n1;
  aesc_block_encrypt DUT (.mclk(mclk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
    .startTrig(startTrig), .stopTrig(stopTrig), .doneEvt(doneEvt), .errEvt(errEvt), .irq(irq),
    .dmaOut(dmaOut), .dmaAck(dmaAck), .dmaRdData(dmaRdData), .coreBusy(coreBusy),
    .coreConflict(coreConflict), .coreReq(coreReq), .coreKey(coreKey), .coreText(coreText),
    .coreDone(coreDone), .coreResult(coreResult));
  aesc_ram_model ram (.mclk(mclk), .sys_rst(sys_rst), .dmaOut(dmaOut), .slow(slow), .dmaAck(dmaAck),
    .dmaRdData(dmaRdData));
  ////////////////////////////////////////////////////////////
  // clock, 25 ns period
  initial forever #12.5 mclk = ~mclk;
  // core stand-in: rotated text mixed into the key shows word order; hold keeps it silent
  always @(posedge mclk) begin
    coreDone <= 1'b0;
    if (coreReq !== 1'b1 || coreHold || coreDone) coreCnt <= 4'h0;
    else if (coreCnt == 4'h8) begin
      coreDone <= 1'b1;
      coreResult <= coreKey ^ {coreText[63:0], coreText[127:64]};
    end else coreCnt <= coreCnt + 4'h1;
  end
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task endSim;
    if (badCount == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : endSim
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk) regReq <= {1'b1, 1'b0, a, d};
    @(posedge mclk) regReq <= '0;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge mclk) regReq <= {1'b0, 1'b1, a, 32'h0};
    @(posedge mclk) regReq <= '0;
    #1 v = regRdData;
  endtask : rd
  task pulse(input logic stop);
    @(posedge mclk) {stopTrig, startTrig} <= {stop, !stop};
    @(posedge mclk) {stopTrig, startTrig} <= 2'h0;
  endtask : pulse
  // bounded wait for an event (w=0) or for the cipher phase (w=1)
  task waitSig(input logic w);
    n = 0;
    #1;
    while (!(w ? coreReq === 1'b1 : (doneEvt === 1'b1 || errEvt === 1'b1))) begin
      @(posedge mclk);
      #1 n++;
      if (n > 400) begin
        badCount++;
        endSim();
      end
    end
  endtask : waitSig
  ////////////////////////////////////////////////////////////
  task tReset;
    rd(12'h304);
    chk("enable reset", v, 32'h0);
    rd(12'h504);
    chk("pointer reset", v, 32'h0);
    rd(12'h200);
    chk("unmapped", v, 32'h0);
    wr(12'h504, 32'h40);
    rd(12'h504);
    chk("pointer", v, 32'h40);
  endtask : tReset
  // run time is counted from the edge that takes the start to the edge of the event
  task tEncrypt(input logic s);
    @(posedge mclk) slow <= s;
    for (int i = 0; i < 8; i++) ram.mem[16+i] = 32'h0a0b0c00 + i + 8 * s;
    wr(12'h304, 32'h3);
    rd(12'h304);
    chk("enable set", v, 32'h3);
    wr(12'h000, 32'h1);
    waitSig(1'b1);
    n1 = n;
    chk("key order", coreKey[127:96], ram.mem[16]);
    chk("text order", coreText[127:96], ram.mem[20]);
    waitSig(1'b0);
    chk("done", doneEvt, 1'b1);
    chk("run time", n + n1 <= `AESC_RUN_MAX_CYC, 1'b1);
    @(posedge mclk);
    #1 chk("irq", irq, 1'b1);
    for (int i = 0; i < 4; i++) chk("cipher", ram.mem[24+i], ram.mem[16+i] ^ ram.mem[20+(i+2)%4]);
    rd(12'h100);
    chk("done flag", v, 32'h1);
    rd(12'h100);
    chk("done cleared", v, 32'h0);
  endtask : tEncrypt
  task tBusy;
    @(posedge mclk) coreBusy <= 1'b1;
    pulse(1'b0);
    waitSig(1'b0);
    chk("busy error", n, 32'h0);
    chk("busy error event", errEvt, 1'b1);
    chk("busy dma", dmaOut.req, 1'b0);
    @(posedge mclk) coreBusy <= 1'b0;
    #1 chk("error irq", irq, 1'b1);
    wr(12'h104, 32'h0);
    rd(12'h104);
    chk("error cleared", v, 32'h0);
    chk("irq low", irq, 1'b0);
  endtask : tBusy
  // aborts: 0 stop register, 1 stop trigger, 2 core conflict, 3 run-time limit, 4 stop during key fetch
  // the limit case also sends a start while running, which must be refused without disturbing the run
  task tAbort(input int m);
    @(posedge mclk) coreHold <= 1'b1;
    pulse(1'b0);
    if (m < 4) waitSig(1'b1);
    n1 = n;
    if (m == 0) wr(12'h004, 32'h1);
    else if (m == 1 || m == 4) pulse(1'b1);
    else if (m == 2) begin
      @(posedge mclk) coreConflict <= 1'b1;
      @(posedge mclk) coreConflict <= 1'b0;
    end else begin
      pulse(1'b0);
      #1 chk("start while running", errEvt, 1'b1);
      chk("run unaffected", coreReq, 1'b1);
      @(posedge mclk);
      n1 = n1 + 3;
    end
    waitSig(1'b0);
    chk("abort error", errEvt, 1'b1);
    if (m == 3) chk("limit", n + n1 >= `AESC_RUN_MAX_CYC && n + n1 <= `AESC_RUN_MAX_CYC + 2, 1'b1);
    chk("abort dma", dmaOut.req, 1'b0);
    @(posedge mclk) coreHold <= 1'b0;
    rd(12'h104);
    chk("error flag", v, 32'h1);
    pulse(1'b1);
    rd(12'h104);
    chk("idle stop", v, 32'h0);
  endtask : tAbort
  task tMask;
    wr(12'h308, 32'h3);
    rd(12'h308);
    chk("enable clear", v, 32'h0);
    pulse(1'b0);
    waitSig(1'b0);
    chk("masked done", doneEvt, 1'b1);
    @(posedge mclk);
    #1 chk("masked irq", irq, 1'b0);
    rd(12'h100);
    chk("masked flag", v, 32'h1);
  endtask : tMask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    tReset();
    tEncrypt(1'b0);
    tEncrypt(1'b1);
    tBusy();
    for (int m = 0; m < 5; m++) tAbort(m);
    tMask();
    endSim();
  end
endmodule : testbench
